/* mctb_pkg.sv */
`default_nettype none
package mctb_pkg;
  // Clock and timebase.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PS = 250;
  localparam int CUR_SAMPLE_US = 200;
  localparam int TEMP_SAMPLE_US = 8000;
  localparam int CUR_BAL_US = 2000;
  localparam int TEMP_BAL_US = 100000;
  localparam int CUR_SAMPLE_CYC = (CUR_SAMPLE_US * 1000000) / CLK_PERIOD_PS;
  localparam int TEMP_SAMPLE_TICKS = TEMP_SAMPLE_US / CUR_SAMPLE_US;
  localparam int CUR_BAL_TICKS = CUR_BAL_US / CUR_SAMPLE_US;
  localparam int TEMP_BAL_TICKS = TEMP_BAL_US / CUR_SAMPLE_US;
  localparam int TICK_CNT_W = 10;
  // Pulse-width arithmetic.
  localparam int DUTY_W = 16;
  localparam int DUTY_FRAC = 11;
  localparam int PRD_W = 16;
  localparam int PRD_PRESCALE = 16;
  localparam int PROD_W = DUTY_W + PRD_W + 1;
  localparam int ROUND_HALF = 1 << (DUTY_FRAC - 1);
  localparam int PW_W = 24;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 16'h8000;
  localparam int F_TICK_KHZ = 1000000000 / TICK_PS;
  localparam int FSW_KHZ_DEF = 500;
  localparam int PRD_DEF = (F_TICK_KHZ + FSW_KHZ_DEF * PRD_PRESCALE / 2)
                           / (FSW_KHZ_DEF * PRD_PRESCALE);
  // Balancing arithmetic.
  localparam int MEAS_W = 16;
  localparam int TRIM_W = 8;
  localparam int LIM_W = TRIM_W - 1;
  localparam int STEP_W = 3;
  localparam int STEP_MA = 125;
  localparam logic [STEP_W-1:0] STEP_MAX = 3'h5;
  // Register map, word index on the register port.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 5'h01;
  localparam logic [ADDR_W-1:0] REG_CUR_LIM = 5'h02;
  localparam logic [ADDR_W-1:0] REG_TEMP_LIM = 5'h03;
  localparam logic [ADDR_W-1:0] REG_TEMP_THR = 5'h04;
  localparam logic [ADDR_W-1:0] REG_MIN_LOAD = 5'h05;
  localparam logic [ADDR_W-1:0] REG_PHASE_MASK = 5'h06;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h07;
  localparam logic [ADDR_W-1:0] REG_TRIM_BASE = 5'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TEMP_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [LIM_W-1:0] CUR_LIM_RST = 7'h20;
  localparam logic [LIM_W-1:0] TEMP_LIM_RST = 7'h20;
  localparam logic [MEAS_W-1:0] TEMP_THR_RST = 16'h0004;
  localparam logic [MEAS_W-1:0] MIN_LOAD_RST = 16'hffff;
endpackage
`default_nettype wire

/* mctb_balance.sv */
// The register addresses and strobed register access are this design's own decisions.
`default_nettype none
module mctb_balance
  import mctb_pkg::*;
#(
  parameter int NPH = 4,
  parameter int SAMPLE_CYC = CUR_SAMPLE_CYC,
  parameter logic [PRD_W-1:0] PRD_RST = PRD_W'(PRD_DEF)
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [ADDR_W-1:0] reg_addr, // Register word index.
  input wire logic [DATA_W-1:0] reg_wr_data, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [DATA_W-1:0] reg_rd_data, // Read data, one cycle later.
  input wire logic soft_start_done, // Pin: soft-start ramp finished.
  input wire logic output_in_regulation, // Pin: rail in regulation.
  input wire logic [DUTY_W-1:0] duty, // Compensated duty word, signed.
  input wire logic [NPH*MEAS_W-1:0] phase_current, // Phase currents, mA.
  input wire logic [NPH*MEAS_W-1:0] phase_temp, // Phase temperatures.
  output logic [NPH*PW_W-1:0] phase_pulse_width, // Widths in ticks, signed.
  output logic balance_active // Balancing running.
);
  localparam int IDX_W = (NPH > 1) ? $clog2(NPH) : 1;
  localparam int LOAD_W = MEAS_W + IDX_W + 1;
  localparam int CYC_W = $clog2(SAMPLE_CYC + 1);

  typedef logic [NPH-1:0][TRIM_W-1:0] mctb_trim_t;

  function automatic logic [TRIM_W-1:0] sat_add(input logic [TRIM_W-1:0] t,
                                                input logic signed [TRIM_W+1:0] d,
                                                input logic [LIM_W-1:0] lim);
    logic signed [TRIM_W+1:0] s;
    logic signed [TRIM_W+1:0] l;
    s = $signed({{2{t[TRIM_W-1]}}, t}) + d;
    l = $signed({3'h0, lim});
    if (s > l) begin
      s = l;
    end else if (s < -l) begin
      s = -l;
    end
    return s[TRIM_W-1:0];
  endfunction

  // Pin synchronisers.
  logic [1:0] ss_sync_ff, pg_sync_ff, nxt_ss_sync, nxt_pg_sync;
  always_comb begin
    nxt_ss_sync = {ss_sync_ff[0], soft_start_done};
    nxt_pg_sync = {pg_sync_ff[0], output_in_regulation};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ss_sync_ff <= 2'h0;
      pg_sync_ff <= 2'h0;
    end else begin
      ss_sync_ff <= nxt_ss_sync;
      pg_sync_ff <= nxt_pg_sync;
    end
  end

  // Registers.
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [PRD_W-1:0] prd_ff, nxt_prd;
  logic [LIM_W-1:0] cur_lim_ff, nxt_cur_lim, tmp_lim_ff, nxt_tmp_lim;
  logic [MEAS_W-1:0] tmp_thr_ff, nxt_tmp_thr, min_load_ff, nxt_min_load;
  logic [NPH-1:0] mask_ff, nxt_mask;
  logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
  logic active_ff, nxt_active;
  logic [STEP_W-1:0] step_ff, nxt_step;
  logic [IDX_W-1:0] c_hi, c_lo, t_hi, t_lo;
  mctb_trim_t cur_trim_ff, nxt_cur_trim, tmp_trim_ff, nxt_tmp_trim;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_prd = prd_ff;
    nxt_cur_lim = cur_lim_ff;
    nxt_tmp_lim = tmp_lim_ff;
    nxt_tmp_thr = tmp_thr_ff;
    nxt_min_load = min_load_ff;
    nxt_mask = mask_ff;
    nxt_rd_data = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: nxt_ctrl = reg_wr_data[1:0];
        REG_PERIOD: nxt_prd = reg_wr_data[PRD_W-1:0];
        REG_CUR_LIM: nxt_cur_lim = reg_wr_data[LIM_W-1:0];
        REG_TEMP_LIM: nxt_tmp_lim = reg_wr_data[LIM_W-1:0];
        REG_TEMP_THR: nxt_tmp_thr = reg_wr_data[MEAS_W-1:0];
        REG_MIN_LOAD: nxt_min_load = reg_wr_data[MEAS_W-1:0];
        REG_PHASE_MASK: nxt_mask = reg_wr_data[NPH-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: nxt_rd_data = DATA_W'(ctrl_ff);
        REG_PERIOD: nxt_rd_data = DATA_W'(prd_ff);
        REG_CUR_LIM: nxt_rd_data = DATA_W'(cur_lim_ff);
        REG_TEMP_LIM: nxt_rd_data = DATA_W'(tmp_lim_ff);
        REG_TEMP_THR: nxt_rd_data = DATA_W'(tmp_thr_ff);
        REG_MIN_LOAD: nxt_rd_data = DATA_W'(min_load_ff);
        REG_PHASE_MASK: nxt_rd_data = DATA_W'(mask_ff);
        REG_STATUS: nxt_rd_data = DATA_W'({active_ff, step_ff, c_lo, c_hi});
        default: begin
          for (int i = 0; i < NPH; i++) begin
            if (reg_addr == REG_TRIM_BASE + ADDR_W'(i)) begin
              nxt_rd_data = {tmp_trim_ff[i], cur_trim_ff[i]};
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
      prd_ff <= PRD_RST;
      cur_lim_ff <= CUR_LIM_RST;
      tmp_lim_ff <= TEMP_LIM_RST;
      tmp_thr_ff <= TEMP_THR_RST;
      min_load_ff <= MIN_LOAD_RST;
      mask_ff <= '1;
      rd_data_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prd_ff <= nxt_prd;
      cur_lim_ff <= nxt_cur_lim;
      tmp_lim_ff <= nxt_tmp_lim;
      tmp_thr_ff <= nxt_tmp_thr;
      min_load_ff <= nxt_min_load;
      mask_ff <= nxt_mask;
      rd_data_ff <= nxt_rd_data;
    end
  end
  assign reg_rd_data = rd_data_ff;

  // Timebase: one 200 us tick drives sampling and both balance periods.
  logic [CYC_W-1:0] cyc_ff, nxt_cyc;
  logic [TICK_CNT_W-1:0] cb_ff, nxt_cb, ts_ff, nxt_ts, tb_ff, nxt_tb;
  logic cur_evt_ff, nxt_cur_evt, tmp_evt_ff, nxt_tmp_evt, tsmp_ff, nxt_tsmp;
  logic tick;
  always_comb begin
    tick = (cyc_ff == CYC_W'(SAMPLE_CYC - 1));
    nxt_cyc = tick ? '0 : cyc_ff + 1'b1;
    nxt_cb = cb_ff;
    nxt_ts = ts_ff;
    nxt_tb = tb_ff;
    nxt_cur_evt = 1'b0;
    nxt_tmp_evt = 1'b0;
    nxt_tsmp = 1'b0;
    if (tick) begin
      nxt_cb = (cb_ff == TICK_CNT_W'(CUR_BAL_TICKS - 1)) ? '0 : cb_ff + 1'b1;
      nxt_ts = (ts_ff == TICK_CNT_W'(TEMP_SAMPLE_TICKS - 1)) ? '0 : ts_ff + 1'b1;
      nxt_tb = (tb_ff == TICK_CNT_W'(TEMP_BAL_TICKS - 1)) ? '0 : tb_ff + 1'b1;
      nxt_cur_evt = (cb_ff == TICK_CNT_W'(CUR_BAL_TICKS - 1));
      nxt_tsmp = (ts_ff == TICK_CNT_W'(TEMP_SAMPLE_TICKS - 1));
      nxt_tmp_evt = (tb_ff == TICK_CNT_W'(TEMP_BAL_TICKS - 1));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_ff <= '0;
      cb_ff <= '0;
      ts_ff <= '0;
      tb_ff <= '0;
      cur_evt_ff <= 1'b0;
      tmp_evt_ff <= 1'b0;
      tsmp_ff <= 1'b0;
    end else begin
      cyc_ff <= nxt_cyc;
      cb_ff <= nxt_cb;
      ts_ff <= nxt_ts;
      tb_ff <= nxt_tb;
      cur_evt_ff <= nxt_cur_evt;
      tmp_evt_ff <= nxt_tmp_evt;
      tsmp_ff <= nxt_tsmp;
    end
  end

  // Stored measurements.
  logic [NPH-1:0][MEAS_W-1:0] cur_ff, nxt_cur, tmp_ff, nxt_tmp;
  always_comb begin
    nxt_cur = tick ? phase_current : cur_ff;
    nxt_tmp = tsmp_ff ? phase_temp : tmp_ff;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
      tmp_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
      tmp_ff <= nxt_tmp;
    end
  end

  // Extremes among enabled phases; ties keep the lowest index.
  logic [IDX_W:0] n_on;
  logic [LOAD_W-1:0] load_sum;
  logic [MEAS_W-1:0] c_spread, t_spread;
  logic [MEAS_W-1:0] c_q;
  logic [STEP_W-1:0] step;
  always_comb begin
    n_on = '0;
    load_sum = '0;
    c_hi = '0;
    c_lo = '0;
    t_hi = '0;
    t_lo = '0;
    for (int i = 0; i < NPH; i++) begin
      if (mask_ff[i]) begin
        if (n_on == '0) begin
          c_hi = IDX_W'(i);
          c_lo = IDX_W'(i);
          t_hi = IDX_W'(i);
          t_lo = IDX_W'(i);
        end else begin
          if (cur_ff[i] > cur_ff[c_hi]) c_hi = IDX_W'(i);
          if (cur_ff[i] < cur_ff[c_lo]) c_lo = IDX_W'(i);
          if (tmp_ff[i] > tmp_ff[t_hi]) t_hi = IDX_W'(i);
          if (tmp_ff[i] < tmp_ff[t_lo]) t_lo = IDX_W'(i);
        end
        n_on = n_on + 1'b1;
        load_sum = load_sum + LOAD_W'(cur_ff[i]);
      end
    end
    c_spread = cur_ff[c_hi] - cur_ff[c_lo];
    t_spread = tmp_ff[t_hi] - tmp_ff[t_lo];
    c_q = c_spread / MEAS_W'(STEP_MA);
    step = (c_q > MEAS_W'(STEP_MAX)) ? STEP_MAX : c_q[STEP_W-1:0];
  end

  // Trim state.
  logic c_ok, t_ok;
  always_comb begin
    nxt_active = ctrl_ff[CTRL_EN_BIT] & ss_sync_ff[1] & pg_sync_ff[1];
    nxt_cur_trim = cur_trim_ff;
    nxt_tmp_trim = tmp_trim_ff;
    nxt_step = step_ff;
    c_ok = (n_on > 1) && (c_hi != c_lo);
    t_ok = (n_on > 1) && (t_hi != t_lo) && ctrl_ff[CTRL_TEMP_BIT] &&
           (t_spread > tmp_thr_ff) && (load_sum >= LOAD_W'(min_load_ff));
    if (!active_ff) begin
      nxt_cur_trim = '0;
      nxt_tmp_trim = '0;
      nxt_step = '0;
    end else begin
      if (cur_evt_ff && c_ok) begin
        nxt_step = step;
        nxt_cur_trim[c_lo] = sat_add(cur_trim_ff[c_lo], (TRIM_W+2)'(step), cur_lim_ff);
        nxt_cur_trim[c_hi] = sat_add(cur_trim_ff[c_hi], -(TRIM_W+2)'(step), cur_lim_ff);
      end
      if (tmp_evt_ff && t_ok) begin
        nxt_tmp_trim[t_lo] = sat_add(tmp_trim_ff[t_lo], (TRIM_W+2)'(1), tmp_lim_ff);
        nxt_tmp_trim[t_hi] = sat_add(tmp_trim_ff[t_hi], -(TRIM_W+2)'(1), tmp_lim_ff);
      end
    end
    // keep trims inside a lowered limit
    for (int i = 0; i < NPH; i++) begin
      nxt_cur_trim[i] = sat_add(nxt_cur_trim[i], '0, cur_lim_ff);
      nxt_tmp_trim[i] = sat_add(nxt_tmp_trim[i], '0, tmp_lim_ff);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_ff <= 1'b0;
      cur_trim_ff <= '0;
      tmp_trim_ff <= '0;
      step_ff <= '0;
    end else begin
      active_ff <= nxt_active;
      cur_trim_ff <= nxt_cur_trim;
      tmp_trim_ff <= nxt_tmp_trim;
      step_ff <= nxt_step;
    end
  end
  assign balance_active = active_ff;

  // Pulse widths, one tick per trim unit.
  logic [NPH-1:0][PW_W-1:0] pw_ff, nxt_pw;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-DUTY_FRAC-1:0] base;
  always_comb begin
    prod = $signed(duty) * $signed({1'b0, prd_ff}) + PROD_W'(ROUND_HALF);
    base = prod[PROD_W-1:DUTY_FRAC];
    for (int i = 0; i < NPH; i++) begin
      nxt_pw[i] = PW_W'(base) + PW_W'($signed(cur_trim_ff[i])) +
                  PW_W'($signed(tmp_trim_ff[i]));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_ff <= '0;
    end else begin
      pw_ff <= nxt_pw;
    end
  end
  assign phase_pulse_width = pw_ff;

  // Checks.
  logic signed [TRIM_W+IDX_W:0] cur_sum;
  logic at_lim, over_lim;
  always_comb begin
    cur_sum = '0;
    at_lim = 1'b0;
    over_lim = 1'b0;
    for (int i = 0; i < NPH; i++) begin
      cur_sum = cur_sum + (TRIM_W+IDX_W+1)'($signed(cur_trim_ff[i]));
      at_lim |= ($signed(cur_trim_ff[i]) == $signed({1'b0, cur_lim_ff})) ||
                ($signed(cur_trim_ff[i]) == -$signed({1'b0, cur_lim_ff}));
      over_lim |= ($signed(cur_trim_ff[i]) > $signed({1'b0, cur_lim_ff})) ||
                  ($signed(tmp_trim_ff[i]) > $signed({1'b0, tmp_lim_ff}));
    end
  end

  sequence s_idle;
    !active_ff;
  endsequence
  sequence s_run_two;
    active_ff ##1 active_ff;
  endsequence

  a_idle_clears: assert property (@(posedge clk) disable iff (rst)
    s_idle |=> (cur_trim_ff == '0) && (tmp_trim_ff == '0))
    else $error("trims not cleared while idle");
  a_gate_regulation: assert property (@(posedge clk) disable iff (rst)
    !pg_sync_ff[1] |=> !active_ff ##1 (cur_trim_ff == '0))
    else $error("balancing active without regulation");
  a_net_charge: assert property (@(posedge clk) disable iff (rst)
    s_run_two ##0 !at_lim |-> cur_sum == $past(cur_sum))
    else $error("net trim changed without saturation");
  a_trim_bound: assert property (@(posedge clk) disable iff (rst)
    !over_lim)
    else $error("trim beyond limit");
  a_step_range: assert property (@(posedge clk) disable iff (rst)
    step_ff <= STEP_MAX)
    else $error("trim step above five");
  a_cur_period: assert property (@(posedge clk) disable iff (rst)
    cur_evt_ff |=> !cur_evt_ff [*8])
    else $error("current balance too frequent");
  a_light_load: assert property (@(posedge clk) disable iff (rst)
    (active_ff && (load_sum < LOAD_W'(min_load_ff))) ##1 active_ff
    |-> $stable(tmp_trim_ff))
    else $error("temperature trim moved at light load");
  a_single_phase: assert property (@(posedge clk) disable iff (rst)
    (active_ff && (n_on < 2)) ##1 active_ff |-> $stable(cur_trim_ff))
    else $error("trim moved with one phase");
  a_current_mode: assert property (@(posedge clk) disable iff (rst)
    !ctrl_ff[CTRL_TEMP_BIT] |=> $stable(tmp_trim_ff) || (tmp_trim_ff == '0))
    else $error("temperature trim moved in current mode");
  a_full_duty: assert property (@(posedge clk) disable iff (rst)
    (duty == DUTY_FULL) && (cur_trim_ff[0] == '0) && (tmp_trim_ff[0] == '0)
    |=> pw_ff[0] == PW_W'(-(PW_W'($past(prd_ff)) * PW_W'(PRD_PRESCALE))))
    else $error("full-scale duty width wrong");
endmodule
`default_nettype wire

/* mctb_stage_model.sv */
`default_nettype none
// Power stages behind the phase outputs: each stage reports the current and
// temperature that the bench dialled in, registered once per clock like a
// sampled front end, and goes to all ones while held in reset.
module mctb_stage_model
  import mctb_pkg::*;
#(
  parameter int NPH = 4
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [NPH*PW_W-1:0] phase_pulse_width, // Commanded widths.
  input wire logic [NPH*MEAS_W-1:0] cur_set, // Bench-chosen stage currents.
  input wire logic [NPH*MEAS_W-1:0] temp_set, // Bench-chosen stage temperatures.
  output logic [NPH*MEAS_W-1:0] phase_current, // Reported currents, mA.
  output logic [NPH*MEAS_W-1:0] phase_temp // Reported temperatures.
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_current <= '1;
      phase_temp <= '1;
    end else begin
      phase_current <= cur_set;
      phase_temp <= temp_set;
    end
  end
endmodule
`default_nettype wire

/* mctb_balance_tb_top.sv */
`default_nettype none
module mctb_balance_tb_top
  import mctb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPH = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wr_data = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rd_data;
  logic soft_start_done = 1'b0;
  logic output_in_regulation = 1'b0;
  logic [DUTY_W-1:0] duty = '0;
  logic [NPH*MEAS_W-1:0] cur_set = {4{16'h03e8}};
  logic [NPH*MEAS_W-1:0] temp_set = {4{16'h0032}};
  logic [NPH*MEAS_W-1:0] phase_current;
  logic [NPH*MEAS_W-1:0] phase_temp;
  logic [NPH*PW_W-1:0] phase_pulse_width;
  logic balance_active;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h002f;
  logic [15:0] prd_v = 16'h01f4;
  logic [15:0] rv;
  logic [63:0] cv;
  int st;
  logic [4:0] ra [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
                          5'h10, 5'h11, 5'h12, 5'h13};
  logic [15:0] rx [12] = '{16'h0000, 16'h01f4, 16'h0020, 16'h0020, 16'h0004, 16'hffff,
                           16'h000f, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int dif [7] = '{0, 124, 125, 300, 624, 625, 2000};
  logic [15:0] tc [4] = '{16'h0003, 16'h0003, 16'h0003, 16'h0001};
  logic [15:0] tt [4] = '{16'h0004, 16'h000a, 16'h0004, 16'h0004};
  logic [15:0] tm [4] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000};
  int te [4] = '{1, 0, 0, 0};

  mctb_balance #(.NPH(NPH), .SAMPLE_CYC(4)) i_mctb_balance (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .soft_start_done(soft_start_done), .output_in_regulation(output_in_regulation),
    .duty(duty), .phase_current(phase_current), .phase_temp(phase_temp),
    .phase_pulse_width(phase_pulse_width), .balance_active(balance_active));
  mctb_stage_model #(.NPH(NPH)) i_mctb_stage_model (
    .clk(clk), .rst(rst), .phase_pulse_width(phase_pulse_width), .cur_set(cur_set),
    .temp_set(temp_set), .phase_current(phase_current), .phase_temp(phase_temp));

  always #2.5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [23:0] exp_w(input logic [15:0] d, input logic [15:0] p,
                                        input int t);
    longint v;
    v = longint'($signed(d)) * longint'(p) + 1024;
    return 24'((v >>> 11) + t);
  endfunction
  function automatic int exp_step(input int diff);
    return (diff / 125 > 5) ? 5 : diff / 125;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Dropping regulation must clear the trims; phase 0's trim word is read back as zero before balancing restarts.
  task automatic restart();
    @(posedge clk);
    output_in_regulation <= 1'b0;
    idle(6);
    rd(REG_TRIM_BASE, rv);
    chk("trim cleared", rv, 0);
    output_in_regulation <= 1'b1;
    idle(4);
  endtask
  task automatic poll(input int ph, input bit hi, input int n, output logic [15:0] d);
    for (int i = 0; i < n; i++) begin
      rd(REG_TRIM_BASE + 5'(ph), d);
      if ((hi ? d[15:8] : d[7:0]) != 8'h00) break;
    end
  endtask
  task automatic chk_w(input int ph, input int t);
    @(posedge clk);
    #1;
    chk("width", 32'(phase_pulse_width[ph*PW_W +: PW_W]), 32'(exp_w(duty, prd_v, t)));
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      $display("ERROR timeout expected 0 seen 1");
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      rd(ra[i], rv);
      chk("reset value", rv, rx[i]);
    end
    wr(5'h09, 16'h1234);
    wr(REG_TRIM_BASE, 16'h1234);
    rd(5'h09, rv);
    chk("unmapped", rv, 0);
    rd(REG_TRIM_BASE, rv);
    chk("read-only trim", rv, 0);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      if (i % 8 == 7) begin
        prd_v = (seed & 16'h0fff) | 16'h0001;
        wr(REG_PERIOD, prd_v);
      end
      @(posedge clk);
      duty <= (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : seed;
      idle(1);
      chk_w(i % 4, 0);
    end
    prd_v = 16'h01f4;
    wr(REG_PERIOD, prd_v);
    duty <= 16'h2000;
    $display("test width done");
    cur_set <= {16'h03e8, 16'h03e8, 16'h07d0, 16'h01f4};
    soft_start_done <= 1'b1;
    output_in_regulation <= 1'b1;
    idle(60);
    chk("active", balance_active, 0);
    soft_start_done <= 1'b0;
    wr(REG_CTRL, 16'h0001);
    idle(60);
    chk("active", balance_active, 0);
    rd(REG_TRIM_BASE, rv);
    chk("idle trim", rv, 0);
    soft_start_done <= 1'b1;
    idle(5);
    chk("active", balance_active, 1);
    $display("test activation done");
    for (int i = 0; i < 7; i++) begin
      for (int p = 0; p < NPH; p++) cv[p*16 +: 16] = 16'(1000 + dif[i] / 2);
      cv[(i % 4)*16 +: 16] = 16'd1000;
      cv[((i + 1) % 4)*16 +: 16] = 16'(1000 + dif[i]);
      cur_set <= cv;
      st = exp_step(dif[i]);
      restart();
      poll(i % 4, 1'b0, 30, rv);
      chk("low trim", rv, 32'(st));
      rd(REG_TRIM_BASE + 5'((i + 1) % 4), rv);
      chk("high trim", rv, 32'({8'h00, 8'(-st)}));
      chk_w(i % 4, st);
    end
    $display("test current balance done");
    wr(REG_CUR_LIM, 16'h0007);
    cur_set <= {16'h07d0, 16'h07d0, 16'h0bb8, 16'h03e8};
    restart();
    idle(130);
    rd(REG_TRIM_BASE, rv);
    chk("saturated low", rv, 32'h7);
    rd(REG_TRIM_BASE + 5'h01, rv);
    chk("saturated high", rv, 32'h00f9);
    wr(REG_PHASE_MASK, 16'h0001);
    restart();
    idle(100);
    rd(REG_TRIM_BASE, rv);
    chk("single phase", rv, 0);
    wr(REG_PHASE_MASK, 16'h000f);
    $display("test limits done");
    wr(REG_CUR_LIM, 16'h0002);
    cur_set <= {16'h02bc, 16'h03e8, 16'h03e8, 16'h03e8};
    temp_set <= {16'h0032, 16'h0037, 16'h003c, 16'h0037};
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, tc[i]);
      wr(REG_TEMP_THR, tt[i]);
      wr(REG_MIN_LOAD, tm[i]);
      restart();
      poll(3, 1'b1, 1100, rv);
      idle(45);
      rd(REG_TRIM_BASE + 5'h03, rv);
      chk("cool trim", rv, 32'({8'(te[i]), 8'h02}));
      rd(REG_TRIM_BASE + 5'h01, rv);
      chk("hot trim", rv, 32'({8'(-te[i]), 8'h00}));
      chk_w(3, 2 + te[i]);
    end
    $display("test temperature balance done");
    stop_test();
  end
endmodule
`default_nettype wire
